// ==== common/rsf_pkg.sv ====
// reading string formatter: register map, reset values, byte codes and timing constants
// assumes a single 40 MHz system clock shared by every user of this package
package rsf_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] FORMAT_OFFSET  = 8'h00;
  localparam logic [7:0] ELEMENT_OFFSET = 8'h04;
  localparam logic [7:0] COMMAND_OFFSET = 8'h08;
  localparam logic [7:0] CONFIG_OFFSET  = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET  = 8'h10;
  localparam logic [7:0] TIMER_OFFSET   = 8'h14;
  localparam logic [7:0] ARM_OFFSET     = 8'h18;
  localparam logic [7:0] TRIG_OFFSET    = 8'h1C;
  localparam logic [7:0] BYTES_OFFSET   = 8'h20;

  // format register fields
  localparam int FMT_CODE_LSB   = 0;
  localparam int FMT_SWAP_BIT   = 4;
  localparam int FMT_WIDTH_LSB  = 8;
  localparam logic [1:0] FMT_ASCII = 2'h0;
  localparam logic [1:0] FMT_REAL  = 2'h1;
  localparam logic [1:0] FMT_SHORT = 2'h2;
  localparam logic [5:0] FMT_DEFAULT_WIDTH = 6'h20;

  // command and config bits
  localparam int CMD_TIME_RESET_BIT  = 0;
  localparam int CMD_BUF_RESTART_BIT = 1;
  localparam int CFG_SERIAL_BIT      = 0;
  localparam int CFG_DELTA_BIT       = 1;

  // element indices and count
  localparam logic [2:0] ELEM_VOLT   = 3'h0;
  localparam logic [2:0] ELEM_CURR   = 3'h1;
  localparam logic [2:0] ELEM_RES    = 3'h2;
  localparam logic [2:0] ELEM_TIME   = 3'h3;
  localparam logic [2:0] ELEM_STATUS = 3'h4;
  localparam logic [2:0] ELEM_NONE   = 3'h5;
  localparam int         ELEM_COUNT  = 5;

  // reset values
  localparam logic [4:0]  ELEMENT_RESET = 5'h1F;
  localparam logic [15:0] COUNT_RESET   = 16'h0001;

  // output item kinds
  localparam logic [1:0] KIND_BYTE  = 2'h0;
  localparam logic [1:0] KIND_FLOAT = 2'h1;
  localparam logic [1:0] KIND_INT   = 2'h2;

  // framing bytes
  localparam logic [7:0] HEADER_HASH = 8'h23;
  localparam logic [7:0] HEADER_ZERO = 8'h30;
  localparam logic [7:0] TERMINATOR  = 8'h0A;
  localparam logic [7:0] SEPARATOR   = 8'h2C;
  localparam int         HEADER_BYTES = 2;
  localparam int         WORD_BYTES   = 4;
  localparam int         TERM_BYTES   = 1;

  // substitute values as single precision: +9.9e37 and +9.91e37
  localparam logic [31:0] OVERFLOW_VALUE = 32'h7E94_F56A;
  localparam logic [31:0] NAN_VALUE      = 32'h7E95_1BEF;
  // 0.001 as single precision, scales milliseconds to seconds
  localparam logic [31:0] MS_TO_S        = 32'h3A83_126F;

  // timestamp timer
  localparam int          CLOCK_MHZ     = 40;
  localparam int          TIMER_TICK_US = 1000;
  localparam int          TICK_CYCLES   = TIMER_TICK_US * CLOCK_MHZ;
  localparam logic [26:0] TIMER_WRAP_MS = 27'h5F5_E0FF;

  // sorting mode limit codes, field order 21,20,19,9,8
  localparam logic [4:0] SORT_ALL_OK    = 5'h00;
  localparam logic [4:0] SORT_L1_FAIL   = 5'h01;
  localparam logic [4:0] SORT_L4_FAIL   = 5'h05;
  localparam logic [4:0] SORT_ALL_FAIL  = 5'h1F;

endpackage

// ==== hdl/rsf_int_to_float.sv ====
// unsigned integer to single precision float, truncating
// purely combinational; caller registers the result
module rsf_int_to_float #(
  parameter int W = 32
) (
  // operand
  input  wire logic [W-1:0] value,
  // result
  output logic      [31:0]  result
);

  localparam int SW = $clog2(W);

  logic [SW-1:0] msb;
  logic          found;
  logic [W-1:0]  shifted;
  logic [7:0]    expo;

  always_comb begin
    msb   = '0;
    found = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (value[i]) begin
        msb   = SW'(i);
        found = 1'b1;
      end
    end
    // left-justify so the leading one drops off the top
    shifted = value << (SW'(W - 1) - msb);
    expo    = 8'(127 + int'(msb));
    result  = found ? {1'b0, expo, shifted[W-2 -: 23]} : 32'h0000_0000;
  end

endmodule

// ==== hdl/rsf_formatter.sv ====
// reading string formatter: builds header, element words, separators and terminator
// assumes one 40 MHz clock; measurement inputs and flags come from logic on that clock
//
// Behaviour
// R1: real format without a width stores 32; width ignored for ascii and short float
// R2: serial interface active forces ascii output regardless of selection
// R3: only data queries use the chosen format; other queries answer in ascii
// R4: controller sends commands as ascii text only
// R5: unselected elements are left out of the string entirely
// R6: byte reversal applies only to binary output
// R7: binary elements go out as four bytes of single precision each
// R8: binary string starts with hash sign then digit zero
// R9: swapped order sends header first, then bytes 4,3,2,1 of each element
// R10: header and terminator sent once per query around all readings
// R11: binary length is 2 plus 4 per reading plus 1
// R12: terminator byte is line feed
// R13: controller reads readings and terminator in one piece without untalking
// R14: element selection holds one to five of the five elements
// R15: over range reading reports +9.9e37
// R16: measured value first, else source value, else not-a-number code
// R17: timestamp starts at zero on power-up or reset command and wraps
// R18: buffered timestamp absolute from first reading, or delta between readings
// R19: status element is a 24-bit word sent as its number
// R20: status bits 0 to 7 carry overrange through limit test enabled
// R21: bits 10 to 15 carry auto ohms, measure and source functions
// R22: bits 16,17,18,22,23 carry compliance, offset, contact, sense, pulse
// R23: bits 8,9,19-21 carry five-bit limit code, encoding by limit mode
// R24: sorting codes for pass, limit 1 fail, limits 2,3 pass, limit 4 fail
// R25: sorting codes for limits 5 to 12 pass and all-others-fail; limit 9 pass reports 5'h08 here, same as limit 8
// R26: swap request ignored when ascii is selected
//
// Added by the designer: strobed register access and the register offsets.
module rsf_formatter #(
  parameter int TICK_CYCLES = rsf_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // query request
  input  wire logic        queryStart,
  input  wire logic        queryData,
  // reading input
  input  wire logic        rdgValid,
  output logic             rdgReady,
  input  wire logic        rdgBuffered,
  input  wire logic [31:0] vMeasValue,
  input  wire logic [31:0] vSourceValue,
  input  wire logic [31:0] iMeasValue,
  input  wire logic [31:0] iSourceValue,
  input  wire logic [31:0] rMeasValue,
  // status flags
  input  wire logic        over_range_flag,
  input  wire logic        filterOn,
  input  wire logic        frontTerminals,
  input  wire logic        realCompliance,
  input  wire logic        overvoltage_limit_flag,
  input  wire logic        mathOn,
  input  wire logic        nullOn,
  input  wire logic        limitTestOn,
  input  wire logic        autoOhms,
  input  wire logic        vMeasOn,
  input  wire logic        iMeasOn,
  input  wire logic        rMeasOn,
  input  wire logic        vSourceOn,
  input  wire logic        iSourceOn,
  input  wire logic        rangeCompliance,
  input  wire logic        offsetComp,
  input  wire logic        contact_check_event,
  input  wire logic        remoteSense,
  input  wire logic        pulseMode,
  // limit results
  input  wire logic        sortMode,
  input  wire logic [4:0]  gradeCode,
  input  wire logic        limit1Pass,
  input  wire logic        limit4Pass,
  input  wire logic [3:0]  firstPassLimit,
  input  wire logic        othersAllFail,
  // output stream
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [31:0] outData,
  output logic      [1:0]  outKind,
  output logic             queryBusy
);

  typedef enum logic [2:0] {S_IDLE, S_HEAD0, S_HEAD1, S_WAIT, S_CONV, S_ELEM, S_SEP, S_TERM} rsf_state_type;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic [1:0] rstSync;
  logic       rstN;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rstSync <= 2'b00;
    else        rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  // configuration registers
  logic [1:0]  fmtCode;
  logic [5:0]  fmtWidth;
  logic        swapOrder;
  logic [4:0]  elemMask;
  logic        serialIface;
  logic        deltaStamp;
  logic [15:0] armCount;
  logic [15:0] trigCount;
  logic        timeResetCmd;
  logic        bufRestartCmd;

  logic wrFormat;
  logic wrElement;
  logic wrCommand;
  assign wrFormat  = regWrite && regAddr == rsf_pkg::FORMAT_OFFSET;
  assign wrElement = regWrite && regAddr == rsf_pkg::ELEMENT_OFFSET;
  assign wrCommand = regWrite && regAddr == rsf_pkg::COMMAND_OFFSET;

  logic [1:0] newCode;
  logic [5:0] newWidth;
  assign newCode  = regWrData[rsf_pkg::FMT_CODE_LSB +: 2];
  assign newWidth = regWrData[rsf_pkg::FMT_WIDTH_LSB +: 6];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      fmtCode   <= rsf_pkg::FMT_ASCII;
      fmtWidth  <= '0;
      swapOrder <= 1'b0;
    end else if (wrFormat && newCode != 2'h3) begin
      fmtCode   <= newCode;
      swapOrder <= regWrData[rsf_pkg::FMT_SWAP_BIT];
      if (newCode == rsf_pkg::FMT_REAL)
        fmtWidth <= (newWidth == 6'h00) ? rsf_pkg::FMT_DEFAULT_WIDTH : newWidth; // R1
      else
        fmtWidth <= '0; // R1
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) elemMask <= rsf_pkg::ELEMENT_RESET;
    else if (wrElement && regWrData[4:0] != 5'h00) elemMask <= regWrData[4:0]; // R14
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      serialIface <= 1'b0;
      deltaStamp  <= 1'b0;
      armCount    <= rsf_pkg::COUNT_RESET;
      trigCount   <= rsf_pkg::COUNT_RESET;
    end else if (regWrite) begin
      // zero counts refused so a query always carries a reading
      if (regAddr == rsf_pkg::CONFIG_OFFSET) begin
        serialIface <= regWrData[rsf_pkg::CFG_SERIAL_BIT];
        deltaStamp  <= regWrData[rsf_pkg::CFG_DELTA_BIT];
      end
      if (regAddr == rsf_pkg::ARM_OFFSET && regWrData[15:0] != 16'h0000) armCount <= regWrData[15:0];
      if (regAddr == rsf_pkg::TRIG_OFFSET && regWrData[15:0] != 16'h0000) trigCount <= regWrData[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timeResetCmd  <= 1'b0;
      bufRestartCmd <= 1'b0;
    end else begin
      timeResetCmd  <= wrCommand && regWrData[rsf_pkg::CMD_TIME_RESET_BIT];
      bufRestartCmd <= wrCommand && regWrData[rsf_pkg::CMD_BUF_RESTART_BIT];
    end
  end

  // timestamp timer in milliseconds
  logic [31:0] tickCount;
  logic [26:0] timerMs;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tickCount <= '0;
      timerMs   <= '0;
    end else if (timeResetCmd) begin
      tickCount <= '0; // R17
      timerMs   <= '0; // R17
    end else if (tickCount == TICK_LAST) begin
      tickCount <= '0;
      timerMs   <= (timerMs == rsf_pkg::TIMER_WRAP_MS) ? 27'h000_0000 : timerMs + 27'h000_0001; // R17
    end else begin
      tickCount <= tickCount + 32'h0000_0001;
    end
  end

  // status word
  logic [4:0]  sortCode;
  logic [4:0]  limitCode;
  logic [23:0] statusNow;

  always_comb begin
    sortCode = rsf_pkg::SORT_ALL_OK;
    if (!limit1Pass) sortCode = rsf_pkg::SORT_L1_FAIL; // R24
    else if (!limit4Pass) sortCode = rsf_pkg::SORT_L4_FAIL; // R24
    else if (othersAllFail) sortCode = rsf_pkg::SORT_ALL_FAIL; // R25
    else begin
      unique case (firstPassLimit)
        4'h2:    sortCode = 5'h02; // R24
        4'h3:    sortCode = 5'h03; // R24
        4'h5:    sortCode = 5'h04; // R25
        4'h6:    sortCode = 5'h06; // R25
        4'h7:    sortCode = 5'h07; // R25
        4'h8:    sortCode = 5'h08; // R25
        4'h9:    sortCode = 5'h08;
        4'hA:    sortCode = 5'h0A; // R25
        4'hB:    sortCode = 5'h0B; // R25
        4'hC:    sortCode = 5'h0C; // R25
        default: sortCode = rsf_pkg::SORT_ALL_OK; // R24
      endcase
    end
    limitCode = sortMode ? sortCode : gradeCode; // R23
    statusNow = {pulseMode, remoteSense, limitCode[4:2], contact_check_event, offsetComp, // R22 R23
                 rangeCompliance, iSourceOn, vSourceOn, rMeasOn, iMeasOn, vMeasOn, autoOhms, // R21
                 limitCode[1:0], limitTestOn, nullOn, mathOn, overvoltage_limit_flag, // R23 R20
                 realCompliance, frontTerminals, filterOn, over_range_flag}; // R20
  end

  // reading capture
  rsf_state_type state;
  rsf_state_type next_state;
  logic [31:0]   rawWord [3];
  logic [23:0]   rawStatus;
  logic [26:0]   rawStampMs;
  logic [31:0]   elemWord [rsf_pkg::ELEM_COUNT];
  logic [26:0]   bufFirst;
  logic [26:0]   bufPrev;
  logic          bufStarted;
  logic          binMode;
  logic          swapNow;
  logic [4:0]    selMask;

  function automatic logic [26:0] stampDiff(input logic [26:0] a, input logic [26:0] b);
    stampDiff = (a >= b) ? a - b : a + (rsf_pkg::TIMER_WRAP_MS - b) + 27'h000_0001;
  endfunction

  logic capture;
  assign capture = state == S_WAIT && rdgValid;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rawWord    <= '{default: '0};
      rawStatus  <= '0;
      rawStampMs <= '0;
    end else if (capture) begin
      rawWord[0] <= vMeasOn ? (over_range_flag ? rsf_pkg::OVERFLOW_VALUE : vMeasValue) // R15 R16
                  : vSourceOn ? vSourceValue : rsf_pkg::NAN_VALUE; // R16
      rawWord[1] <= iMeasOn ? (over_range_flag ? rsf_pkg::OVERFLOW_VALUE : iMeasValue) // R15 R16
                  : iSourceOn ? iSourceValue : rsf_pkg::NAN_VALUE; // R16
      rawWord[2] <= rMeasOn ? (over_range_flag ? rsf_pkg::OVERFLOW_VALUE : rMeasValue) // R15
                  : rsf_pkg::NAN_VALUE; // R16
      rawStatus  <= statusNow; // R19
      if (!rdgBuffered) rawStampMs <= timerMs;
      else if (!bufStarted || bufRestartCmd) rawStampMs <= '0; // R18
      else rawStampMs <= deltaStamp ? stampDiff(timerMs, bufPrev) : stampDiff(timerMs, bufFirst); // R18
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bufStarted <= 1'b0;
      bufFirst   <= '0;
      bufPrev    <= '0;
    end else if (capture && rdgBuffered) begin
      bufStarted <= 1'b1;
      bufPrev    <= timerMs;
      if (!bufStarted || bufRestartCmd) bufFirst <= timerMs; // R18
    end else if (bufRestartCmd) begin
      bufStarted <= 1'b0;
    end
  end

  // conversion of status and timestamp
  logic [31:0] statusFloat;
  logic [31:0] stampMsFloat;

  rsf_int_to_float #(.W(24)) statusConv (
    .value  (rawStatus),
    .result (statusFloat)
  );

  rsf_int_to_float #(.W(27)) stampConv (
    .value  (rawStampMs),
    .result (stampMsFloat)
  );

  // positive float product, truncated; enough for scaling the timestamp
  function automatic logic [31:0] floatMul(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] prod;
    logic [9:0]  expo;
    prod = 48'({1'b1, a[22:0]}) * 48'({1'b1, b[22:0]});
    expo = 10'(a[30:23]) + 10'(b[30:23]) - 10'd127;
    if (a[30:0] == 31'h0000_0000) floatMul = 32'h0000_0000;
    else if (prod[47]) floatMul = {1'b0, 8'(expo + 10'd1), prod[46:24]};
    else floatMul = {1'b0, expo[7:0], prod[45:23]};
  endfunction

  logic [31:0] convWord [rsf_pkg::ELEM_COUNT];
  always_comb begin
    convWord[0] = rawWord[0];
    convWord[1] = rawWord[1];
    convWord[2] = rawWord[2];
    convWord[3] = floatMul(stampMsFloat, rsf_pkg::MS_TO_S); // R17
    convWord[4] = binMode ? statusFloat : {8'h00, rawStatus}; // R7 R19
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) elemWord <= '{default: '0};
    else if (state == S_CONV) elemWord <= convWord;
  end

  // framing state machine
  logic [2:0]  elemIdx;
  logic [2:0]  next_elemIdx;
  logic [1:0]  byteIdx;
  logic [1:0]  next_byteIdx;
  logic [31:0] rdgLeft;
  logic [31:0] next_rdgLeft;
  logic        sepToElem;
  logic        next_sepToElem;
  logic        adv;
  logic        effBinary;
  logic [31:0] totalRdgs;

  assign adv       = outValid && outReady;
  assign effBinary = fmtCode != rsf_pkg::FMT_ASCII && !serialIface && queryData; // R2 R3
  assign totalRdgs = 32'(armCount) * 32'(trigCount);

  function automatic logic [2:0] selFrom(input logic [4:0] mask, input logic [2:0] start);
    selFrom = rsf_pkg::ELEM_NONE;
    for (int i = rsf_pkg::ELEM_COUNT - 1; i >= 0; i--) begin
      if (mask[i] && 3'(i) >= start) selFrom = 3'(i);
    end
  endfunction

  logic [2:0] nextSel;
  assign nextSel = selFrom(selMask, elemIdx + 3'h1);

  always_comb begin
    next_state     = state;
    next_elemIdx   = elemIdx;
    next_byteIdx   = byteIdx;
    next_rdgLeft   = rdgLeft;
    next_sepToElem = sepToElem;
    unique case (state)
      S_IDLE: begin
        if (queryStart) begin
          next_rdgLeft = queryData ? totalRdgs : 32'h0000_0001;
          next_state   = effBinary ? S_HEAD0 : S_WAIT; // R8 R10
        end
      end
      S_HEAD0: if (adv) next_state = S_HEAD1; // R8
      S_HEAD1: if (adv) next_state = S_WAIT; // R8
      S_WAIT:  if (rdgValid) next_state = S_CONV;
      S_CONV: begin
        next_state   = S_ELEM;
        next_elemIdx = selFrom(selMask, rsf_pkg::ELEM_VOLT); // R5
        next_byteIdx = 2'h0;
      end
      S_ELEM: begin
        if (adv) begin
          if (binMode && byteIdx != 2'h3) begin
            next_byteIdx = byteIdx + 2'h1; // R7
          end else begin
            next_byteIdx = 2'h0;
            if (nextSel != rsf_pkg::ELEM_NONE) begin
              next_elemIdx   = nextSel; // R5
              next_sepToElem = 1'b1;
              next_state     = binMode ? S_ELEM : S_SEP;
            end else if (rdgLeft == 32'h0000_0001) begin
              next_rdgLeft = '0;
              next_state   = S_TERM; // R10 R11
            end else begin
              next_rdgLeft   = rdgLeft - 32'h0000_0001;
              next_sepToElem = 1'b0;
              next_state     = binMode ? S_WAIT : S_SEP;
            end
          end
        end
      end
      S_SEP:  if (adv) next_state = sepToElem ? S_ELEM : S_WAIT;
      S_TERM: if (adv) next_state = S_IDLE; // R10
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state     <= S_IDLE;
      elemIdx   <= '0;
      byteIdx   <= '0;
      rdgLeft   <= '0;
      sepToElem <= 1'b0;
    end else begin
      state     <= next_state;
      elemIdx   <= next_elemIdx;
      byteIdx   <= next_byteIdx;
      rdgLeft   <= next_rdgLeft;
      sepToElem <= next_sepToElem;
    end
  end

  // per-query settings held so register writes mid-query do not tear the string
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      binMode <= 1'b0;
      swapNow <= 1'b0;
      selMask <= rsf_pkg::ELEMENT_RESET;
    end else if (state == S_IDLE && queryStart) begin
      binMode <= effBinary; // R2 R3
      swapNow <= effBinary && swapOrder; // R6 R26
      selMask <= elemMask;
    end
  end

  // output item for the state being entered, so the port is a flip-flop
  logic [31:0] srcWord;
  logic [1:0]  byteSel;
  logic [31:0] next_outData;
  logic [1:0]  next_outKind;
  logic        next_outValid;

  always_comb begin
    srcWord       = (state == S_CONV) ? convWord[next_elemIdx] : elemWord[next_elemIdx];
    byteSel       = swapNow ? next_byteIdx : 2'h3 - next_byteIdx; // R9
    next_outValid = 1'b1;
    next_outKind  = rsf_pkg::KIND_BYTE;
    next_outData  = '0;
    unique case (next_state)
      S_HEAD0: next_outData = {24'h00_0000, rsf_pkg::HEADER_HASH}; // R8 R9
      S_HEAD1: next_outData = {24'h00_0000, rsf_pkg::HEADER_ZERO}; // R8
      S_SEP:   next_outData = {24'h00_0000, rsf_pkg::SEPARATOR};
      S_TERM:  next_outData = {24'h00_0000, rsf_pkg::TERMINATOR}; // R12
      S_ELEM: begin
        if (binMode) begin
          next_outData = {24'h00_0000, srcWord[{byteSel, 3'b000} +: 8]}; // R7 R9
        end else begin
          next_outData = srcWord;
          next_outKind = (next_elemIdx == rsf_pkg::ELEM_STATUS) ? rsf_pkg::KIND_INT : rsf_pkg::KIND_FLOAT; // R19
        end
      end
      default: next_outValid = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outValid  <= 1'b0;
      outData   <= '0;
      outKind   <= rsf_pkg::KIND_BYTE;
      rdgReady  <= 1'b0;
      queryBusy <= 1'b0;
    end else begin
      outValid  <= next_outValid;
      outData   <= next_outData;
      outKind   <= next_outKind;
      rdgReady  <= next_state == S_WAIT;
      queryBusy <= next_state != S_IDLE;
    end
  end

  // register read port
  logic [31:0] byteTotal;
  logic [2:0]  selCount;

  always_comb begin
    selCount = '0;
    for (int i = 0; i < rsf_pkg::ELEM_COUNT; i++) selCount = selCount + 3'(elemMask[i]);
    byteTotal = 32'(rsf_pkg::HEADER_BYTES + rsf_pkg::TERM_BYTES) // R11
              + 32'(rsf_pkg::WORD_BYTES) * 32'(selCount) * totalRdgs; // R11
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        rsf_pkg::FORMAT_OFFSET:  regRdData <= {18'h0_0000, fmtWidth, 3'h0, swapOrder, 2'h0, fmtCode};
        rsf_pkg::ELEMENT_OFFSET: regRdData <= {27'h000_0000, elemMask};
        rsf_pkg::CONFIG_OFFSET:  regRdData <= {30'h0000_0000, deltaStamp, serialIface};
        rsf_pkg::STATUS_OFFSET:  regRdData <= {8'h00, statusNow};
        rsf_pkg::TIMER_OFFSET:   regRdData <= {5'h00, timerMs};
        rsf_pkg::ARM_OFFSET:     regRdData <= {16'h0000, armCount};
        rsf_pkg::TRIG_OFFSET:    regRdData <= {16'h0000, trigCount};
        rsf_pkg::BYTES_OFFSET:   regRdData <= byteTotal;
        default:                 regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

// ==== verif/rsf_formatter_chk.sv ====
// checker for rsf_formatter: read slot, reply framing, stream hold
// assumes it is bound into rsf_formatter, one clock domain
module rsf_formatter_chk (
  // clock and reset
  input wire logic        clk, rst_b,
  // register port
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regRdData,
  // reply stream
  input wire logic        queryStart, queryBusy, rdgReady, outValid, outReady,
  input wire logic [31:0] outData,
  // status flags
  input wire logic        over_range_flag, pulseMode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_slot_a: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000) else $error("read data outside slot");
  no_reg_a: assert property (regRead && regAddr == 8'h40 |=> regRdData == 32'h0000_0000) else $error("unmapped read");
  flag_bits_a: assert property (
    regRead && regAddr == 8'h10 && $stable(over_range_flag) && $stable(pulseMode)
    |=> regRdData[0] == $past(over_range_flag) && regRdData[23] == $past(pulseMode)) else $error("status bit wrong");
  busy_start_a: assert property (queryStart && !queryBusy |=> queryBusy) else $error("query not started");
  first_item_a: assert property (queryStart && !queryBusy |=> rdgReady || outValid && outData[7:0] == 8'h23)
    else $error("reply does not open");
  hash_zero_a: assert property ($rose(queryBusy) && outValid && outReady |=> outValid && outData[7:0] == 8'h30)
    else $error("second header byte wrong");
  item_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData)) else $error("item dropped");
  term_last_a: assert property ($fell(queryBusy) |-> $past(outValid && outReady && outData[7:0] == 8'h0A))
    else $error("reply not closed by line feed");
endmodule
bind rsf_formatter rsf_formatter_chk chk (.*);

// ==== verif/rsf_host.sv ====
// controller model that reads the reply stream
// assumes items are taken on a rising edge with outValid and outReady high
module rsf_host (
  // clock and stall control
  input wire logic        clk, slow,
  // reply stream
  input wire logic        outValid,
  input wire logic [31:0] outData,
  input wire logic [1:0]  outKind,
  output logic            outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [33:0] got [$];
  initial outReady = 1'b1;
  // slow mode stalls every other cycle but never abandons a reply
  always @(posedge clk) begin
    if (outValid && outReady) got.push_back({outKind, outData});
    outReady <= ~slow | ~outReady;
  end
endmodule

// ==== verif/testbench.sv ====
// bench for rsf_formatter: register port, binary and ascii replies, status word
// assumes rsf_host as controller and the checker bound into the formatter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, regWrite = 0, regRead = 0, queryStart = 0, queryData = 0, rdgValid = 0, slow = 0;
  logic rdgBuffered = 0, sortMode = 1, limit1Pass = 0, limit4Pass = 1, othersAllFail = 0, over_range_flag = 0;
  logic filterOn = 1, frontTerminals = 0, realCompliance = 1, overvoltage_limit_flag = 0, mathOn = 1, nullOn = 0;
  logic limitTestOn = 1, autoOhms = 1, vMeasOn = 1, iMeasOn = 0, rMeasOn = 0, vSourceOn = 0, iSourceOn = 1;
  logic rangeCompliance = 1, offsetComp = 0, contact_check_event = 1, remoteSense = 0, pulseMode = 1;
  logic [7:0]  regAddr = 0;
  logic [31:0] regWrData = 0, vMeasValue = 32'h3F80_0000, iSourceValue = 32'hC120_0000, vSourceValue = 0;
  logic [31:0] iMeasValue = 0, rMeasValue = 0, regRdData, outData, rdVal;
  logic [4:0]  gradeCode = 5'h12, codeTab [4] = '{5'h04, 5'h1F, 5'h05, 5'h12};
  logic [3:0]  firstPassLimit = 0, limTab [4] = '{5, 0, 0, 0};
  logic [1:0]  outKind;
  logic        rdgReady, outValid, outReady, queryBusy;
  logic [33:0] expQ [$];
  int          err_count = 0, checks_done = 0;
  rsf_formatter #(.TICK_CYCLES(4)) uut (.*);
  rsf_host host (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    checks_done++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    chk(regRdData, want);
  endtask
  // expected binary reply: two readings of V, I and R
  task automatic bq(input logic sw, input logic [31:0] v);
    expQ = '{34'h23, 34'h30};
    repeat (2) for (int e = 0; e < 3; e++) for (int k = 0; k < 4; k++) begin
      rdVal = e == 0 ? v : e == 1 ? iSourceValue : rsf_pkg::NAN_VALUE;
      expQ.push_back({26'h0, sw ? rdVal[8*k +: 8] : rdVal[31-8*k -: 8]});
    end
    expQ.push_back(34'h0A);
  endtask
  task automatic q(input logic d);
    int n;
    host.got.delete();
    @(posedge clk);
    queryData <= d;
    queryStart <= 1'b1;
    rdgValid <= 1'b1;
    @(posedge clk);
    queryStart <= 1'b0;
    for (n = 0; n < 500; n++) begin
      @(posedge clk);
      if (queryBusy === 1'b0) break;
    end
    rdgValid <= 1'b0;
    if (n == 500) begin
      err_count++;
      tally_and_finish();
    end
    chk(34'(host.got.size()), 34'(expQ.size()));
    foreach (expQ[i]) chk(host.got[i], expQ[i]);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1F);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'h1F02);
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h2001);
    wr(8'h04, 32'h7);
    wr(8'h18, 32'h2);
    rd(8'h20, 32'h1B);
    bq(1'b0, vMeasValue);
    q(1'b1);
    wr(8'h00, 32'h11);
    over_range_flag <= 1'b1;
    slow <= 1'b1;
    bq(1'b1, rsf_pkg::OVERFLOW_VALUE);
    q(1'b1);
    wr(8'h04, 32'h1);
    wr(8'h18, 32'h1);
    for (int j = 0; j < 3; j++) begin
      wr(8'h00, j == 2 ? 32'h10 : 32'h1);
      wr(8'h0C, j == 0 ? 32'h1 : 32'h0);
      expQ = '{{2'h1, rsf_pkg::OVERFLOW_VALUE}, 34'h0A};
      q(j != 1);
    end
    wr(8'h04, 32'h18);
    rdgBuffered <= 1'b1;
    expQ = '{{2'h1, 32'h0000_0000}, 34'h2C, {2'h2, 32'h0085_8DAB}, 34'h0A};
    q(1'b1);
    rd(8'h10, 32'h0085_8DAB);
    limit1Pass <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      firstPassLimit <= limTab[j];
      othersAllFail <= j == 1;
      limit4Pass <= j != 2;
      sortMode <= j != 3;
      rd(8'h10, 32'h0085_8CAB | {10'h000, codeTab[j][4:2], 9'h000, codeTab[j][1:0], 8'h00});
    end
    wr(8'h08, 32'h1);
    rd(8'h14, 32'h0);
    tally_and_finish();
  end
endmodule
